/* File: hdl/ccs_pkg.sv */
/*
 Package for the comparator control and status block: register offsets,
 field positions, reset values, codes and the configuration carrier.
 Assumes a 32-bit register port with byte offsets that are word aligned.
*/
package ccs_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0]  CCS_OFS_CTRL_STATUS = 8'h00;
   localparam logic [7:0]  CCS_OFS_SCAN        = 8'h04;

   // ==========================================================
   // Field positions in the control and status register and the scan register
   localparam int          CCS_POS_LOCK        = 31;
   localparam int          CCS_POS_RESULT      = 30;
   localparam int          CCS_POS_SRC_SEL     = 29;
   localparam int          CCS_POS_WIN_EN      = 28;
   localparam int          CCS_POS_WIN_SRC     = 25;
   localparam int          CCS_POS_FILTER      = 18;
   localparam int          CCS_POS_MARGIN      = 16;
   localparam int          CCS_POS_MODE        = 2;
   localparam int          CCS_POS_SCAN_PERIOD = 0;

   // Writable bits of the lower half (reserved bits 14, 9 and 1 masked)
   localparam logic [15:0] CCS_LOW_MASK        = 16'hBDFD;

   // ==========================================================
   // Reset values
   localparam logic [15:0] CCS_RST_LOW         = 16'h0000;
   localparam logic [7:0]  CCS_RST_SCAN_PERIOD = 8'h00;
   localparam logic [31:0] CCS_RD_UNMAPPED     = 32'h0000_0000;

   // ==========================================================
   // Codes
   localparam logic [1:0]  CCS_MODE_HIGH_SPEED = 2'h0;

   typedef enum logic [2:0] {
      CCS_WIN_TA_REF  = 3'b000,
      CCS_WIN_TA_TRIG = 3'b001,
      CCS_WIN_TB_TRIG = 3'b010,
      CCS_WIN_TC_REF  = 3'b100,
      CCS_WIN_TD_REF  = 3'b101
   } ccs_win_src_e;

   // ==========================================================
   // Configuration carrier
   typedef struct packed {
      logic        lock;
      logic        src_sel;
      logic        win_en;
      logic [2:0]  win_src;
      logic [2:0]  filter;
      logic [1:0]  margin;
      logic [15:0] low;
   } ccs_cfg_s;

   localparam ccs_cfg_s    CCS_RST_CFG = '{lock: 1'b0, src_sel: 1'b0, win_en: 1'b0, win_src: 3'h0,
                                           filter: 3'h0, margin: 2'h0, low: CCS_RST_LOW};

endpackage : ccs_pkg

/* File: hdl/ccs_window_gate.sv */
/*
 Window gate: holds the last sample of the result while the gating signal
 is low and passes the result straight through when gating is off.
 Assumes the gating signal is synchronous to the clock.
*/
`timescale 1ns/1ns
module ccs_window_gate
   import ccs_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Control
   input  wire logic enable,
   input  wire logic gating_signal,
   // Data
   input  wire logic din,
   output logic      gated_result
);

   logic held;
   logic next_held;

   // ==========================================================
   // Sampling
   always_comb begin
      next_held = held;
      if (enable && gating_signal) begin
         next_held = din;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         held <= 1'b0;
      end else begin
         held <= next_held;
      end
   end

   assign gated_result = enable ? held : din;

endmodule // ccs_window_gate

/* File: hdl/ccs_pulse_filter.sv */
/*
 Pulse filter: the output follows the input only after the input has held
 a new level for the programmed number of cycles; zero passes at once.
 Assumes the period input is stable while a pulse is being timed.
*/
`timescale 1ns/1ns
module ccs_pulse_filter
   import ccs_pkg::*;
#(
   parameter int CNT_W = 16
)(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Control
   input  wire logic [CNT_W-1:0] period,
   // Data
   input  wire logic             din,
   output logic                  dout
);

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             next_dout;

   // ==========================================================
   // Stability counter
   always_comb begin
      next_cnt  = '0;
      next_dout = dout;
      if (period == '0) begin
         next_dout = din;
      end else if (din != dout) begin
         if (cnt + 1'b1 >= period) begin
            next_dout = din;
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt  <= '0;
         dout <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         dout <= next_dout;
      end
   end

endmodule // ccs_pulse_filter

/* File: hdl/ccs_top.sv */
/*
 Comparator control and status register bank for one comparator: freeze
 bit, result flag, result source, window gating, output filter and margin
 select, plus the scan register that holds the filter multiplier.
 Assumes a plain register port with read data one cycle after the strobe,
 timer window sources synchronous to the clock, and an analog core that
 takes the configuration outputs.
*/
// Chosen here: the placing of the registers and strobed register access.
// How it works
// - The freeze bit at bit 31 can be set once by software and later writes to it do nothing.
// - The freeze bit only clears on system reset, never by software.
// - While frozen both the control register and the scan register ignore writes, otherwise both are writable.
// - Bit 30 reads 1 when the positive input is above the negative input and 0 otherwise.
// - Bit 29 selects the raw comparator signal when 1 and the synchronised one when 0.
// - With bit 29 set the raw result reaches the wake output with no clock involved.
// - Bit 28 turns window gating on when 1 and off when 0.
// - With gating on the result is sampled every clock while the gate is high and held while it is low.
// - With gating off the result goes straight to the pulse filter.
// - Bits 27:25 choose the gate: 000, 001, 010, 100, 101 pick the five timer signals, others pick none.
// - The filter drops pulses shorter than its period and passes longer ones.
// - Filter code 000 disables filtering and codes 001 to 111 give 2n up to 128n cycles.
// - The multiplier n is the wait count held in the scan register.
// - Bits 17:16 choose the margin, 85/45/22/0 mV in high speed mode and 60/32/15/0 mV otherwise.
// - The power mode field reads 00 high speed, 01 medium, 10 low speed, 11 very low speed.
`timescale 1ns/1ns
module ccs_top
   import ccs_pkg::*;
#(
   parameter int SCAN_PERIOD_W = 8,
   parameter int FILTER_CNT_W  = 16
)(
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   // Register port
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   // Comparator core
   input  wire logic        CMP_RAW,
   // Timer window sources
   input  wire logic        TIMER_A_CHANNEL_REF,
   input  wire logic        TIMER_A_TRIGGER,
   input  wire logic        TIMER_B_TRIGGER,
   input  wire logic        TIMER_C_CHANNEL_REF,
   input  wire logic        TIMER_D_CHANNEL_REF,
   // Result outputs
   output logic             RESULT_OUT,
   output logic             WAKE_OUT,
   // Configuration to the analog core
   output logic             LOCKED,
   output logic      [1:0]  MODE_SEL,
   output logic      [1:0]  MARGIN_SEL,
   output logic      [6:0]  MARGIN_MV,
   output logic      [15:0] CTRL_LOW
);

   // ==========================================================
   // Decoding functions

   // Gate chosen by the window source field
   function automatic logic win_gate(input logic [2:0] code,
                                     input logic [4:0] srcs);
      logic g;
      g = 1'b0;
      case (code)
         CCS_WIN_TA_REF:  g = srcs[0];
         CCS_WIN_TA_TRIG: g = srcs[1];
         CCS_WIN_TB_TRIG: g = srcs[2];
         CCS_WIN_TC_REF:  g = srcs[3];
         CCS_WIN_TD_REF:  g = srcs[4];
         default:         g = 1'b0;
      endcase
      return g;
   endfunction

   // Shift that turns n into the filter period
   function automatic logic [3:0] filter_shift(input logic [2:0] code);
      logic [3:0] s;
      s = 4'h0;
      case (code)
         3'b001:  s = 4'h1;
         3'b010:  s = 4'h2;
         3'b011:  s = 4'h3;
         3'b100:  s = 4'h4;
         3'b101:  s = 4'h5;
         3'b110:  s = 4'h6;
         3'b111:  s = 4'h7;
         default: s = 4'h0;
      endcase
      return s;
   endfunction

   // Margin in millivolts for a mode and code
   function automatic logic [6:0] margin_mv(input logic [1:0] mode,
                                            input logic [1:0] code);
      logic [6:0] mv;
      mv = 7'h00;
      if (mode == CCS_MODE_HIGH_SPEED) begin
         case (code)
            2'b11:   mv = 7'd85;
            2'b10:   mv = 7'd45;
            2'b01:   mv = 7'd22;
            default: mv = 7'd0;
         endcase
      end else begin
         case (code)
            2'b11:   mv = 7'd60;
            2'b10:   mv = 7'd32;
            2'b01:   mv = 7'd15;
            default: mv = 7'd0;
         endcase
      end
      return mv;
   endfunction

   // ==========================================================
   // Declarations
   ccs_cfg_s                  cfg;
   ccs_cfg_s                  next_cfg;
   logic [SCAN_PERIOD_W-1:0]  scan_period;
   logic [SCAN_PERIOD_W-1:0]  next_scan_period;
   logic [31:0]               next_rdata;
   logic [31:0]               csr_view;
   logic [31:0]               scan_view;
   logic                      sync_stage1;
   logic                      sync_stage2;
   logic                      next_sync_stage1;
   logic                      next_sync_stage2;
   logic [1:0]                next_mode;
   logic [1:0]                next_margin_sel;
   logic [6:0]                next_margin_mv;
   logic                      sel_result;
   logic                      gate;
   logic                      gated;
   logic                      filtered;
   logic [FILTER_CNT_W-1:0]   filter_period;
   logic                      wr_csr;
   logic                      wr_scan;
   logic                      wake_sel;
   logic                      next_wake_sel;

   // ==========================================================
   // Register writes
   assign wr_csr  = WR && (ADDR == CCS_OFS_CTRL_STATUS) && !cfg.lock;
   assign wr_scan = WR && (ADDR == CCS_OFS_SCAN) && !cfg.lock;

   always_comb begin
      next_cfg         = cfg;
      next_scan_period = scan_period;
      if (wr_csr) begin
         next_cfg.lock    = WDATA[CCS_POS_LOCK];
         next_cfg.src_sel = WDATA[CCS_POS_SRC_SEL];
         next_cfg.win_en  = WDATA[CCS_POS_WIN_EN];
         next_cfg.win_src = WDATA[CCS_POS_WIN_SRC +: 3];
         next_cfg.filter  = WDATA[CCS_POS_FILTER +: 3];
         next_cfg.margin  = WDATA[CCS_POS_MARGIN +: 2];
         next_cfg.low     = WDATA[15:0] & CCS_LOW_MASK;
      end
      if (wr_scan) begin
         next_scan_period = WDATA[CCS_POS_SCAN_PERIOD +: SCAN_PERIOD_W];
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         cfg         <= CCS_RST_CFG;
         scan_period <= CCS_RST_SCAN_PERIOD[SCAN_PERIOD_W-1:0];
      end else begin
         cfg         <= next_cfg;
         scan_period <= next_scan_period;
      end
   end

   // ==========================================================
   // Register reads
   always_comb begin
      csr_view                          = 32'h0000_0000;
      csr_view[CCS_POS_LOCK]            = cfg.lock;
      csr_view[CCS_POS_RESULT]          = filtered;
      csr_view[CCS_POS_SRC_SEL]         = cfg.src_sel;
      csr_view[CCS_POS_WIN_EN]          = cfg.win_en;
      csr_view[CCS_POS_WIN_SRC +: 3]    = cfg.win_src;
      csr_view[CCS_POS_FILTER +: 3]     = cfg.filter;
      csr_view[CCS_POS_MARGIN +: 2]     = cfg.margin;
      csr_view[15:0]                    = cfg.low;
      scan_view                         = 32'h0000_0000;
      scan_view[CCS_POS_SCAN_PERIOD +: SCAN_PERIOD_W] = scan_period;
      next_rdata = CCS_RD_UNMAPPED;
      if (RD) begin
         case (ADDR)
            CCS_OFS_CTRL_STATUS: next_rdata = csr_view;
            CCS_OFS_SCAN:        next_rdata = scan_view;
            default:             next_rdata = CCS_RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         RDATA <= CCS_RD_UNMAPPED;
      end else begin
         RDATA <= next_rdata;
      end
   end

   // ==========================================================
   // Result synchroniser
   always_comb begin
      next_sync_stage1 = CMP_RAW;
      next_sync_stage2 = sync_stage1;
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         sync_stage1 <= 1'b0;
         sync_stage2 <= 1'b0;
      end else begin
         sync_stage1 <= next_sync_stage1;
         sync_stage2 <= next_sync_stage2;
      end
   end

   // ==========================================================
   // Result path
   assign sel_result = cfg.src_sel ? CMP_RAW : sync_stage2;

   assign gate = win_gate(cfg.win_src, {TIMER_D_CHANNEL_REF, TIMER_C_CHANNEL_REF,
                                        TIMER_B_TRIGGER, TIMER_A_TRIGGER,
                                        TIMER_A_CHANNEL_REF});

   ccs_window_gate u_window (
      .clk           (CLK_SYS),
      .rst           (RST),
      .enable        (cfg.win_en),
      .gating_signal (gate),
      .din           (sel_result),
      .gated_result  (gated)
   );

   assign filter_period = (cfg.filter == 3'b000) ? '0
                        : FILTER_CNT_W'({{(FILTER_CNT_W-SCAN_PERIOD_W){1'b0}}, scan_period}
                                        << filter_shift(cfg.filter));

   ccs_pulse_filter #(
      .CNT_W (FILTER_CNT_W)
   ) u_filter (
      .clk    (CLK_SYS),
      .rst    (RST),
      .period (filter_period),
      .din    (gated),
      .dout   (filtered)
   );

   assign RESULT_OUT = filtered;

   // ==========================================================
   // Wake path, free of the clock once selected
   always_comb begin
      next_wake_sel = cfg.src_sel;
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         wake_sel <= 1'b0;
      end else begin
         wake_sel <= next_wake_sel;
      end
   end

   assign WAKE_OUT = wake_sel ? CMP_RAW : filtered;

   // ==========================================================
   // Configuration outputs
   always_comb begin
      next_mode       = next_cfg.low[CCS_POS_MODE +: 2];
      next_margin_sel = next_cfg.margin;
      next_margin_mv  = margin_mv(next_mode, next_cfg.margin);
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         MODE_SEL   <= 2'h0;
         MARGIN_SEL <= 2'h0;
         MARGIN_MV  <= 7'h00;
      end else begin
         MODE_SEL   <= next_mode;
         MARGIN_SEL <= next_margin_sel;
         MARGIN_MV  <= next_margin_mv;
      end
   end

   assign LOCKED   = cfg.lock;
   assign CTRL_LOW = cfg.low;

endmodule // ccs_top

/* File: tb/ccs_top_assertions.sv */
/*
 Checker for the comparator control and status block.
 Assumes it is bound to ccs_top and sees only its ports.
*/
`timescale 1ns/1ns
module ccs_chk
   import ccs_pkg::*;
(
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        RST,
   // Register port
   input wire logic [7:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [31:0] RDATA,
   // Result and configuration
   input wire logic        CMP_RAW,
   input wire logic        RESULT_OUT,
   input wire logic        WAKE_OUT,
   input wire logic        LOCKED,
   input wire logic [1:0]  MODE_SEL,
   input wire logic [1:0]  MARGIN_SEL,
   input wire logic [6:0]  MARGIN_MV,
   input wire logic [15:0] CTRL_LOW
);
   logic [6:0] exp_mv;
   logic       raw_sel;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // ==========================================================
   // Expected margin
   always_comb begin
      case (MARGIN_SEL)
         2'h3:    exp_mv = (MODE_SEL == CCS_MODE_HIGH_SPEED) ? 7'h55 : 7'h3C;
         2'h2:    exp_mv = (MODE_SEL == CCS_MODE_HIGH_SPEED) ? 7'h2D : 7'h20;
         2'h1:    exp_mv = (MODE_SEL == CCS_MODE_HIGH_SPEED) ? 7'h16 : 7'h0F;
         default: exp_mv = 7'h00;
      endcase
   end
   // ==========================================================
   // Source select as last written
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         raw_sel <= 1'b0;
      end else if (WR && ADDR == CCS_OFS_CTRL_STATUS && !LOCKED) begin
         raw_sel <= WDATA[CCS_POS_SRC_SEL];
      end
   end
   // ==========================================================
   // Sequences and assertions
   sequence s_csr_rd;
      RD && ADDR == CCS_OFS_CTRL_STATUS;
   endsequence
   sequence s_lock_wr;
      WR && ADDR == CCS_OFS_CTRL_STATUS && WDATA[CCS_POS_LOCK];
   endsequence
   a_lock_set: assert property (s_lock_wr ##0 !LOCKED |=> LOCKED)
      else $error("lock write did not set the freeze bit");
   a_lock_cause: assert property ($rose(LOCKED) |-> $past(WR && ADDR == 8'h00 && WDATA[31]))
      else $error("freeze bit rose without a lock write");
   a_lock_sticky: assert property (LOCKED |=> LOCKED)
      else $error("freeze bit cleared without reset");
   a_frozen_cfg: assert property (LOCKED && $past(LOCKED) |-> $stable(CTRL_LOW) && $stable(MARGIN_SEL)
                                  && $stable(MODE_SEL))
      else $error("configuration changed while frozen");
   a_margin_value: assert property (MARGIN_MV == exp_mv)
      else $error("margin value does not match mode and code");
   a_wake_raw: assert property (raw_sel && $past(raw_sel) |-> WAKE_OUT == CMP_RAW)
      else $error("wake output does not follow the raw result");
   a_wake_filtered: assert property (!raw_sel && !$past(raw_sel) |-> WAKE_OUT == RESULT_OUT)
      else $error("wake output does not follow the filtered result");
   a_csr_view: assert property (s_csr_rd |=> RDATA[31:30] == {$past(LOCKED), $past(RESULT_OUT)}
      && RDATA[24:21] == 4'h0 && RDATA[17:16] == $past(MARGIN_SEL) && RDATA[15:0] == $past(CTRL_LOW))
      else $error("control read view wrong");
   a_rd_idle: assert property (!RD || (ADDR != 8'h00 && ADDR != 8'h04) |=> RDATA == 32'h0000_0000)
      else $error("read data not zero outside a mapped read");
endmodule // ccs_chk

bind ccs_top ccs_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .CMP_RAW(CMP_RAW), .RESULT_OUT(RESULT_OUT), .WAKE_OUT(WAKE_OUT), .LOCKED(LOCKED),
   .MODE_SEL(MODE_SEL), .MARGIN_SEL(MARGIN_SEL), .MARGIN_MV(MARGIN_MV), .CTRL_LOW(CTRL_LOW));

/* File: tb/ccs_far_model.sv */
/*
 Model of the analog comparator core and the timer window sources.
 Assumes callers step it from the clock; outputs change just after an edge.
*/
`timescale 1ns/1ns
module ccs_far_model (
   // Clock
   input  wire logic clk,
   // Compare result and window sources
   output logic       cmp_raw,
   output logic [4:0] gates
);
   initial begin
      cmp_raw = 1'b0;
      gates   = 5'h00;
   end
   // Analog compare: positive input above negative gives 1
   task automatic set_inputs(input int vp_mv, input int vn_mv);
      @(posedge clk);
      cmp_raw <= (vp_mv > vn_mv);
   endtask
   // Timer sources, synchronous to the clock
   task automatic set_gates(input logic [4:0] g);
      @(posedge clk);
      gates <= g;
   endtask
endmodule // ccs_far_model

/* File: tb/ccs_top_tb.sv */
/*
 Testbench for the comparator control and status block.
 Assumes the far-side model drives the compare result and timer sources.
*/
`timescale 1ns/1ns
module ccs_top_tb import ccs_pkg::*;;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic        cmp_raw, result_out, wake_out, locked;
   logic [4:0]  gates;
   logic [1:0]  mode_sel, margin_sel;
   logic [6:0]  margin_mv;
   logic        lvl = 1'b0;
   int          failures = 0;
   int          total_checks = 0;
   int          n;
   logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
   logic [6:0]  mv_tbl [8] = '{7'h00, 7'h16, 7'h2D, 7'h55, 7'h00, 7'h0F, 7'h20, 7'h3C};

   always #20 clk = ~clk;

   ccs_far_model far (.clk(clk), .cmp_raw(cmp_raw), .gates(gates));
   ccs_top dut (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .CMP_RAW(cmp_raw), .TIMER_A_CHANNEL_REF(gates[0]), .TIMER_A_TRIGGER(gates[1]),
      .TIMER_B_TRIGGER(gates[2]), .TIMER_C_CHANNEL_REF(gates[3]), .TIMER_D_CHANNEL_REF(gates[4]),
      .RESULT_OUT(result_out), .WAKE_OUT(wake_out), .LOCKED(locked), .MODE_SEL(mode_sel),
      .MARGIN_SEL(margin_sel), .MARGIN_MV(margin_mv), .CTRL_LOW());

   // ==========================================================
   // Tasks
   task automatic stop_test();
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask
   task automatic drive();
      far.set_inputs(lvl ? 10 : 0, 5);
   endtask
   // Flip the compare result and count edges until the output follows
   task automatic flip(input int exp_n);
      lvl = ~lvl;
      drive();
      n = 0;
      while (result_out !== lvl && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(n, exp_n);
      if (n == 400) stop_test();
   endtask
   task automatic pulse(input int w, input logic pass);
      logic seen;
      seen = 1'b0;
      lvl = ~lvl;
      drive();
      repeat (w - 1) @(posedge clk);
      lvl = ~lvl;
      drive();
      repeat (10) begin
         @(posedge clk);
         #1;
         if (result_out !== lvl) seen = 1'b1;
      end
      check(seen, pass);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_reg(CCS_OFS_CTRL_STATUS, 32'h0000_0000);
      rd_reg(8'h08, 32'h0000_0000);
      wr_reg(CCS_OFS_CTRL_STATUS, 32'h7FFF_FFFF);
      rd_reg(CCS_OFS_CTRL_STATUS, 32'h3E1F_BDFD);
      for (int m = 0; m < 4; m++) begin
         for (int h = 0; h < 4; h++) begin
            wr_reg(CCS_OFS_CTRL_STATUS, {14'h0, 2'(h), 12'h0, 2'(m), 2'h0});
            check(margin_mv, mv_tbl[(m == 0 ? 0 : 4) + h]);
            check(mode_sel, m);
            check(margin_sel, h);
            rd_reg(CCS_OFS_CTRL_STATUS, {14'h0, 2'(h), 12'h0, 2'(m), 2'h0});
         end
      end
      flip(3);
      wr_reg(CCS_OFS_CTRL_STATUS, 32'h2000_0000);
      flip(1);
      lvl = ~lvl;
      drive();
      #1;
      check(wake_out, lvl);
      repeat (2) @(posedge clk);
      rd_reg(CCS_OFS_CTRL_STATUS, 32'h6000_0000);
      wr_reg(CCS_OFS_SCAN, 32'h0000_0002);
      for (int c = 0; c < 8; c++) begin
         wr_reg(CCS_OFS_CTRL_STATUS, {4'h2, 7'h0, 3'(c), 18'h0});
         flip(c == 0 ? 1 : 2 << c);
      end
      wr_reg(CCS_OFS_CTRL_STATUS, 32'h2004_0000);
      pulse(3, 1'b0);
      pulse(4, 1'b1);
      for (int i = 0; i < 6; i++) begin
         far.set_gates(5'h1F);
         wr_reg(CCS_OFS_CTRL_STATUS, {4'h3, codes[i], 25'h0});
         repeat (4) @(posedge clk);
         far.set_gates(~(5'h01 << i));
         lvl = ~lvl;
         drive();
         repeat (6) @(posedge clk);
         #1;
         check(result_out, !lvl);
         far.set_gates(5'h01 << i);
         repeat (4) @(posedge clk);
         #1;
         check(result_out, (i == 5) ? !lvl : lvl);
      end
      wr_reg(CCS_OFS_CTRL_STATUS, 32'h2000_0000);
      repeat (3) @(posedge clk);
      #1;
      check(result_out, lvl);
      wr_reg(CCS_OFS_SCAN, 32'h0000_0005);
      rd_reg(CCS_OFS_SCAN, 32'h0000_0005);
      wr_reg(CCS_OFS_CTRL_STATUS, 32'h8002_0004);
      check(locked, 1'b1);
      wr_reg(CCS_OFS_CTRL_STATUS, 32'h0000_0000);
      repeat (3) @(posedge clk);
      rd_reg(CCS_OFS_CTRL_STATUS, 32'h8002_0004 | (32'(lvl) << 30));
      wr_reg(CCS_OFS_SCAN, 32'h0000_0009);
      rd_reg(CCS_OFS_SCAN, 32'h0000_0005);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      check(locked, 1'b0);
      wr_reg(CCS_OFS_SCAN, 32'h0000_0007);
      rd_reg(CCS_OFS_SCAN, 32'h0000_0007);
      stop_test();
   end
endmodule // ccs_top_tb
